// >>> include/cmsl_pkg.sv
package cmsl_pkg;

  // ==========================================================================
  // Link timing
  // ==========================================================================
  localparam int unsigned CLK_HZ            = 20_000_000;
  localparam int unsigned BIT_THRESH_NS     = 2000;
  localparam int unsigned BIT_THRESH_CYC    = (BIT_THRESH_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned GAP_TIMEOUT_US    = 20;
  localparam int unsigned GAP_TIMEOUT_CYC   = GAP_TIMEOUT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned PHASE1_US         = 1000;
  localparam int unsigned PHASE1_CYC_DEF    = PHASE1_US * (CLK_HZ / 1_000_000);
  localparam int unsigned HALF_BIT_NS       = 4000;
  localparam int unsigned HALF_BIT_CYC      = (HALF_BIT_NS * (CLK_HZ / 1_000_000)) / 1000;

  // ==========================================================================
  // Frame layout
  // ==========================================================================
  localparam logic [15:0] ENTRY_KEY         = 16'h5A5A;
  localparam int unsigned KEY_BITS          = 16;
  localparam int unsigned CMD_BITS          = 14;
  localparam int unsigned TX_BITS           = 18;
  localparam logic [1:0]  TX_START          = 2'h2;
  localparam logic [2:0]  SV_NORMAL         = 3'h5;
  localparam logic [2:0]  SV_PARITY_ERR     = 3'h6;
  localparam int unsigned CMD_DATA_LSB      = 0;
  localparam int unsigned CMD_ADDR_LSB      = 8;
  localparam int unsigned CMD_RW_POS        = 12;
  localparam int unsigned CMD_PAR_POS       = 13;
  localparam logic        CMD_WRITE         = 1'h0;

  // ==========================================================================
  // Register file
  // ==========================================================================
  localparam logic [3:0]  ADDR_THIRD_CONFIG_REGISTER        = 4'h2;
  localparam logic [3:0]  ADDR_EXIT         = 4'hA;
  localparam logic [7:0]  EXIT_DATA         = 8'h80;
  localparam int unsigned LOCK_BIT_POS      = 7;
  localparam int unsigned ANALOG_TEST_OUTPUT_ENABLE_BIT_POS      = 0;
  localparam logic [7:0]  REG_RESET         = 8'h00;

  // ==========================================================================
  // AXI4-Lite map
  // ==========================================================================
  localparam logic [7:0]  AXI_CTRL          = 8'h00;
  localparam logic [7:0]  AXI_STATUS        = 8'h04;
  localparam logic [7:0]  AXI_REGS          = 8'h40;
  localparam int unsigned CTRL_SYNC_MODE    = 0;
  localparam int unsigned CTRL_FAIL         = 1;
  localparam int unsigned CTRL_OTP_DONE     = 2;
  localparam logic [1:0]  RESP_OKAY         = 2'h0;
  localparam logic [1:0]  RESP_SLVERR       = 2'h2;

  typedef enum logic [1:0] {ST_PHASE1, ST_CONFIG, ST_NORMAL} cmsl_mode_t;

endpackage

// >>> src/cmsl_top.sv
`timescale 1ns/10ps
// What this block does
// - supply-fail reset: no frames, idle current
// - test output only when enable bit is 1
// - key accepted only during first start-up phase
// - compare all sixteen bits against 0x5A5A
// - commands are 14 bits, key 16
// - traffic arrives as supply-pin pulse durations
// - key accepted: reply with third config register
// - no key: later pulses sync or ignored
// - fixed reply format, no sync or auto-zero
// - Manchester-1 frame starting with bits 10b
// - 18 bits total, payload LSB first
// - parity, address, data, state vector layout
// - normal reply state vector is 101b
// - payload parity is even
// - command: parity, flag, address, data
// - flag 0 writes, flag 1 reads
// - parity error: vector 110b, zero fields
// - write stores, echoes back; locked writes ignored
// - read ignores data, returns register
// - 0x80 to 1010b exits, restarts initialisation
module cmsl_top #(
  parameter int unsigned PHASE1_CYC = cmsl_pkg::PHASE1_CYC_DEF
) (
  // Clock and reset.
  input  wire logic        REF_CLK,
  input  wire logic        RSTN,
  // Supply-fail reset from the regulator monitor.
  input  wire logic        SUPPLY_FAIL,
  // Supply-pin pulse detector, asynchronous.
  input  wire logic        BUS_SUPPLY_PULSE,
  // Current-mode transmitter, sync event, test output enable and config mode flag.
  output logic             BUS_CURRENT_HIGH,
  output logic             SYNC_PULSE_EVENT,
  output logic             ANALOG_TEST_OUTPUT_ENABLE,
  output logic             CONFIG_MODE,
  // AXI4-Lite slave.
  input  wire logic [7:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic [1:0]           sync;
    logic                 pin;
    cmsl_pkg::cmsl_mode_t mode;
    logic [31:0]          phase_cnt;
    logic [15:0]          pw_cnt;
    logic [15:0]          gap_cnt;
    logic [15:0]          rx_sr;
    logic [4:0]           rx_n;
    logic [127:0]         regs;
    logic                 tx_busy;
    logic [35:0]          tx_sr;
    logic [5:0]           tx_n;
    logic [15:0]          tx_cnt;
    logic                 tx_exit;
    logic                 cur;
    logic                 sync_ev;
    logic                 sync_mode;
    logic                 aw_got;
    logic                 w_got;
    logic [7:0]           aw_addr;
    logic [31:0]          w_data;
    logic                 bvalid;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    logic [1:0]           bresp;
    logic                 aw_rdy;
    logic                 w_rdy;
    logic                 ar_rdy;
    logic                 cfg;
  } cmsl_state_t;

  cmsl_state_t s_q;
  cmsl_state_t s_d;

  // Builds the 36 half-bit Manchester-1 line levels, sent from bit 0 upward.
  function automatic logic [35:0] cmsl_frame(input logic [3:0] a, input logic [7:0] d,
                                             input logic [2:0] sv);
    logic [15:0] pl;
    logic [17:0] bits;
    logic [35:0] half;
    pl        = {1'h0, a, d, sv};
    pl[15]    = ^pl[14:0];
    bits      = {pl, cmsl_pkg::TX_START[0], cmsl_pkg::TX_START[1]};
    half      = '0;
    for (int i = 0; i < 18; i++) begin
      half[2*i]   = bits[i];
      half[2*i+1] = ~bits[i];
    end
    return half;
  endfunction

  logic [3:0]  c_addr;
  logic [7:0]  c_data;
  logic [7:0]  c_cur;
  logic        locked;
  logic        bit_val;
  logic        pin_fall;
  logic        pin_rise;
  logic [3:0]  ra;

  always_comb begin
    s_d      = s_q;
    c_addr   = s_q.rx_sr[cmsl_pkg::CMD_ADDR_LSB +: 4];
    c_data   = s_q.rx_sr[cmsl_pkg::CMD_DATA_LSB +: 8];
    c_cur    = s_q.regs[{c_addr, 3'h0} +: 8];
    locked   = s_q.regs[{cmsl_pkg::ADDR_THIRD_CONFIG_REGISTER, 3'h0} + 7'(cmsl_pkg::LOCK_BIT_POS)];
    bit_val  = s_q.pw_cnt >= 16'(cmsl_pkg::BIT_THRESH_CYC);
    ra       = 4'h0;
    s_d.sync    = {s_q.sync[0], BUS_SUPPLY_PULSE};
    s_d.pin     = s_q.sync[1];
    pin_rise    = s_q.sync[1] & ~s_q.pin;
    pin_fall    = ~s_q.sync[1] & s_q.pin;
    s_d.sync_ev = 1'b0;

    // ========================================================================
    // Pulse-duration receiver
    // ========================================================================
    if (pin_rise) begin
      s_d.pw_cnt = 16'h0000;
    end else if (s_q.pin && s_q.pw_cnt != 16'hFFFF) begin
      s_d.pw_cnt = s_q.pw_cnt + 16'h0001;
    end
    if (s_q.phase_cnt != 32'hFFFFFFFF) begin
      s_d.phase_cnt = s_q.phase_cnt + 32'h1;
    end
    if (pin_fall) begin
      s_d.gap_cnt = 16'h0000;
    end else if (s_q.gap_cnt != 16'hFFFF) begin
      s_d.gap_cnt = s_q.gap_cnt + 16'h0001;
    end

    case (s_q.mode)
      cmsl_pkg::ST_PHASE1: begin
        if (pin_fall) begin
          s_d.rx_sr = {bit_val, s_q.rx_sr[15:1]};
          if ({bit_val, s_q.rx_sr[15:1]} == cmsl_pkg::ENTRY_KEY && !s_q.tx_busy) begin
            s_d.mode    = cmsl_pkg::ST_CONFIG;
            s_d.rx_sr   = 16'h0000;
            s_d.rx_n    = 5'h00;
            s_d.tx_busy = 1'b1;
            s_d.tx_n    = 6'h00;
            s_d.tx_cnt  = 16'h0000;
            s_d.tx_sr   = cmsl_frame(cmsl_pkg::ADDR_THIRD_CONFIG_REGISTER,
                                     s_q.regs[{cmsl_pkg::ADDR_THIRD_CONFIG_REGISTER, 3'h0} +: 8],
                                     cmsl_pkg::SV_NORMAL);
          end
        end
        if (s_q.phase_cnt >= 32'(PHASE1_CYC) && s_d.mode == cmsl_pkg::ST_PHASE1) begin
          s_d.mode = cmsl_pkg::ST_NORMAL;
        end
      end
      cmsl_pkg::ST_CONFIG: begin
        if (pin_fall && !s_q.tx_busy) begin
          s_d.rx_sr = {bit_val, s_q.rx_sr[15:1]};
          s_d.rx_n  = s_q.rx_n + 5'h01;
        end
        if (s_q.rx_n != 5'h00 && s_q.gap_cnt >= 16'(cmsl_pkg::GAP_TIMEOUT_CYC)) begin
          s_d.rx_n  = 5'h00;
          s_d.rx_sr = 16'h0000;
        end else if (s_q.rx_n == 5'(cmsl_pkg::CMD_BITS) && !s_q.tx_busy) begin
          c_addr      = s_q.rx_sr[15-13+cmsl_pkg::CMD_ADDR_LSB +: 4];
          c_data      = s_q.rx_sr[15-13+cmsl_pkg::CMD_DATA_LSB +: 8];
          c_cur       = s_q.regs[{c_addr, 3'h0} +: 8];
          s_d.rx_n    = 5'h00;
          s_d.rx_sr   = 16'h0000;
          s_d.tx_busy = 1'b1;
          s_d.tx_n    = 6'h00;
          s_d.tx_cnt  = 16'h0000;
          if (^s_q.rx_sr[15:2]) begin
            s_d.tx_sr = cmsl_frame(4'h0, 8'h00, cmsl_pkg::SV_PARITY_ERR);
          end else if (s_q.rx_sr[2+cmsl_pkg::CMD_RW_POS] == cmsl_pkg::CMD_WRITE) begin
            if (c_addr == cmsl_pkg::ADDR_EXIT && c_data == cmsl_pkg::EXIT_DATA) begin
              s_d.tx_exit = 1'b1;
              s_d.tx_sr   = cmsl_frame(c_addr, c_data, cmsl_pkg::SV_NORMAL);
            end else if (!locked) begin
              s_d.regs[{c_addr, 3'h0} +: 8] = c_data;
              s_d.tx_sr = cmsl_frame(c_addr, c_data, cmsl_pkg::SV_NORMAL);
            end else begin
              s_d.tx_sr = cmsl_frame(c_addr, c_cur, cmsl_pkg::SV_NORMAL);
            end
          end else begin
            s_d.tx_sr = cmsl_frame(c_addr, c_cur, cmsl_pkg::SV_NORMAL);
          end
        end
      end
      cmsl_pkg::ST_NORMAL: begin
        s_d.sync_ev = pin_fall & s_q.sync_mode;
      end
      default: begin
        s_d.mode = cmsl_pkg::ST_PHASE1;
      end
    endcase

    // ========================================================================
    // Manchester transmitter
    // ========================================================================
    s_d.cur = 1'b0;
    if (s_q.tx_busy) begin
      s_d.cur = s_q.tx_sr[0];
      if (s_q.tx_cnt == 16'(cmsl_pkg::HALF_BIT_CYC - 1)) begin
        s_d.tx_cnt = 16'h0000;
        s_d.tx_sr  = {1'b0, s_q.tx_sr[35:1]};
        s_d.tx_n   = s_q.tx_n + 6'h01;
        if (s_q.tx_n == 6'(2 * cmsl_pkg::TX_BITS - 1)) begin
          s_d.tx_busy = 1'b0;
          if (s_q.tx_exit) begin
            s_d.tx_exit   = 1'b0;
            s_d.mode      = cmsl_pkg::ST_PHASE1;
            s_d.phase_cnt = 32'h0;
            s_d.rx_sr     = 16'h0000;
          end
        end
      end else begin
        s_d.tx_cnt = s_q.tx_cnt + 16'h0001;
      end
    end

    // ========================================================================
    // AXI4-Lite slave
    // ========================================================================
    if (AWVALID && !s_q.aw_got && !s_q.bvalid) begin
      s_d.aw_got  = 1'b1;
      s_d.aw_addr = AWADDR;
    end
    if (WVALID && !s_q.w_got && !s_q.bvalid) begin
      s_d.w_got  = 1'b1;
      s_d.w_data = WDATA;
    end
    if (s_q.aw_got && s_q.w_got) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = cmsl_pkg::RESP_OKAY;
      if (s_q.aw_addr[7:2] == cmsl_pkg::AXI_CTRL[7:2]) begin
        if (WSTRB[0] || 1'b1) begin
          s_d.sync_mode = s_q.w_data[cmsl_pkg::CTRL_SYNC_MODE];
        end
      end else if (s_q.aw_addr[7:2] != cmsl_pkg::AXI_STATUS[7:2]) begin
        s_d.bresp = cmsl_pkg::RESP_SLVERR;
      end
    end
    if (s_q.bvalid && BREADY) begin
      s_d.bvalid = 1'b0;
    end
    if (ARVALID && !s_q.rvalid) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = cmsl_pkg::RESP_OKAY;
      s_d.rdata  = 32'h0;
      ra         = ARADDR[5:2];
      if (ARADDR[7:2] == cmsl_pkg::AXI_CTRL[7:2]) begin
        s_d.rdata[cmsl_pkg::CTRL_SYNC_MODE] = s_q.sync_mode;
      end else if (ARADDR[7:2] == cmsl_pkg::AXI_STATUS[7:2]) begin
        s_d.rdata = {25'h0, s_q.tx_busy, s_q.rx_n[3:0], s_q.mode};
      end else if (ARADDR[7:6] == cmsl_pkg::AXI_REGS[7:6]) begin
        s_d.rdata = {24'h0, s_q.regs[{ra, 3'h0} +: 8]};
      end else begin
        s_d.rresp = cmsl_pkg::RESP_SLVERR;
      end
    end
    if (s_q.rvalid && RREADY) begin
      s_d.rvalid = 1'b0;
    end

    // Supply-fail holds the link silent and restarts start-up.
    if (SUPPLY_FAIL) begin
      s_d.tx_busy   = 1'b0;
      s_d.cur       = 1'b0;
      s_d.tx_exit   = 1'b0;
      s_d.mode      = cmsl_pkg::ST_PHASE1;
      s_d.phase_cnt = 32'h0;
      s_d.rx_n      = 5'h00;
      s_d.rx_sr     = 16'h0000;
    end

    // ========================================================================
    // Output registers
    // ========================================================================
    // Readies and the mode flag are registered copies of the next state, so
    // every output leaves the block from a flip-flop with unchanged timing.
    s_d.aw_rdy = !s_d.aw_got && !s_d.bvalid;
    s_d.w_rdy  = !s_d.w_got && !s_d.bvalid;
    s_d.ar_rdy = !s_d.rvalid;
    s_d.cfg    = s_d.mode == cmsl_pkg::ST_CONFIG;
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      s_q      <= '0;
      s_q.mode   <= cmsl_pkg::ST_PHASE1;
      s_q.aw_rdy <= 1'b1;
      s_q.w_rdy  <= 1'b1;
      s_q.ar_rdy <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign BUS_CURRENT_HIGH          = s_q.cur;
  assign SYNC_PULSE_EVENT          = s_q.sync_ev;
  assign ANALOG_TEST_OUTPUT_ENABLE = s_q.regs[{cmsl_pkg::ADDR_THIRD_CONFIG_REGISTER, 3'h0}];
  assign CONFIG_MODE               = s_q.cfg;
  assign AWREADY                   = s_q.aw_rdy;
  assign WREADY                    = s_q.w_rdy;
  assign BVALID                    = s_q.bvalid;
  assign BRESP                     = s_q.bresp;
  assign ARREADY                   = s_q.ar_rdy;
  assign RVALID                    = s_q.rvalid;
  assign RDATA                     = s_q.rdata;
  assign RRESP                     = s_q.rresp;

endmodule

// >>> verif/cmsl_asserts.sv
`timescale 1ns/10ps
// ====================
// Link and bus checks.
module cmsl_asserts (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RSTN,
  // Link side.
  input wire logic SUPPLY_FAIL,
  input wire logic BUS_CURRENT_HIGH,
  input wire logic SYNC_PULSE_EVENT,
  input wire logic ANALOG_TEST_OUTPUT_ENABLE,
  input wire logic CONFIG_MODE,
  // Bus side.
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic BVALID,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic RVALID
);
  logic [7:0] run_q;
  // Counts how long the current line has held its level.
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      run_q <= 8'h00;
    end else if ($changed(BUS_CURRENT_HIGH)) begin
      run_q <= 8'h01;
    end else if (run_q != 8'hFF) begin
      run_q <= run_q + 8'h01;
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  a_fail_idle: assert property (SUPPLY_FAIL && $past(SUPPLY_FAIL) |-> !BUS_CURRENT_HIGH)
    else $error("current high in fail reset");
  a_half_len: assert property ($fell(BUS_CURRENT_HIGH) |-> run_q == 8'h50 || run_q == 8'hA0)
    else $error("high level of wrong length");
  a_sync_single: assert property (SYNC_PULSE_EVENT |=> !SYNC_PULSE_EVENT)
    else $error("sync event longer than one cycle");
  a_sync_not_cfg: assert property (CONFIG_MODE |-> !SYNC_PULSE_EVENT)
    else $error("sync event in config mode");
  a_test_en_cfg: assert property ($rose(ANALOG_TEST_OUTPUT_ENABLE) |-> CONFIG_MODE)
    else $error("test output enabled outside config");
  a_key_reply: assert property ($rose(CONFIG_MODE) |-> ##[0:3] BUS_CURRENT_HIGH)
    else $error("no reply after key");
  a_write_ans: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID)
    else $error("write response late");
  a_read_ans: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read data late");
endmodule
bind cmsl_top cmsl_asserts cmsl_asserts_inst (
  .REF_CLK(REF_CLK), .RSTN(RSTN), .SUPPLY_FAIL(SUPPLY_FAIL),
  .BUS_CURRENT_HIGH(BUS_CURRENT_HIGH), .SYNC_PULSE_EVENT(SYNC_PULSE_EVENT),
  .ANALOG_TEST_OUTPUT_ENABLE(ANALOG_TEST_OUTPUT_ENABLE), .CONFIG_MODE(CONFIG_MODE),
  .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY),
  .BVALID(BVALID), .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID)
);

// >>> verif/cmsl_host_model.sv
`timescale 1ns/10ps
// ====================
// Control module on the far side of the link.
module cmsl_host_model (
  // Device clock, used only to time the reply.
  input wire logic ref_clk,
  // Link lines.
  input wire logic bus_current_high,
  output logic     bus_supply_pulse
);
  logic link_clk = 1'h0;
  initial bus_supply_pulse = 1'h0;
  // The link clock runs only while a frame is sent.
  task automatic ticks(input int n);
    repeat (n) begin
      link_clk = 1'h1;
      #200 link_clk = 1'h0;
      #200;
    end
  endtask
  task automatic send_frame(input logic [15:0] v, input int n);
    #13;
    for (int i = 0; i < n; i++) begin
      ticks(3);
      bus_supply_pulse = 1'h1;
      ticks(v[i] ? 8 : 3);
      bus_supply_pulse = 1'h0;
    end
  endtask
  task automatic recv_frame(output logic [15:0] pl, output logic ok);
    logic [35:0] h;
    int          w;
    ok = 1'h0;
    pl = 16'h0000;
    w = 0;
    while (bus_current_high !== 1'h1 && w < 1000) begin
      @(posedge ref_clk);
      #1 w++;
    end
    if (w < 1000) begin
      repeat (40) @(posedge ref_clk);
      for (int k = 0; k < 36; k++) begin
        #1 h[k] = bus_current_high;
        repeat (80) @(posedge ref_clk);
      end
      ok = h[0] & ~h[2];
      for (int b = 0; b < 18; b++) ok &= h[2*b] ^ h[2*b+1];
      for (int b = 0; b < 16; b++) pl[b] = h[2*b+4];
    end
  endtask
endmodule

// >>> verif/cmsl_top_bench.sv
`timescale 1ns/10ps
module cmsl_top_bench;
  // ====================
  // Signals
  logic        REF_CLK = 1'h0;
  logic        RSTN = 1'h0;
  logic        SUPPLY_FAIL = 1'h0;
  logic        BUS_SUPPLY_PULSE, BUS_CURRENT_HIGH, SYNC_PULSE_EVENT;
  logic        ANALOG_TEST_OUTPUT_ENABLE, CONFIG_MODE;
  logic [7:0]  AWADDR = 8'h00;
  logic [7:0]  ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic        AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0]  BRESP, RRESP, rr;
  logic [31:0] RDATA, rd;
  logic [15:0] pl;
  logic        ok;
  int          num_errors = 0, comparisons = 0, cyc = 0, sync_cnt = 0, n;
  cmsl_top #(.PHASE1_CYC(6000)) cmsl_top_inst (
    .REF_CLK(REF_CLK), .RSTN(RSTN), .SUPPLY_FAIL(SUPPLY_FAIL),
    .BUS_SUPPLY_PULSE(BUS_SUPPLY_PULSE), .BUS_CURRENT_HIGH(BUS_CURRENT_HIGH),
    .SYNC_PULSE_EVENT(SYNC_PULSE_EVENT), .ANALOG_TEST_OUTPUT_ENABLE(ANALOG_TEST_OUTPUT_ENABLE),
    .CONFIG_MODE(CONFIG_MODE), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(4'hF), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY)
  );
  cmsl_host_model cmsl_host_model_inst (
    .ref_clk(REF_CLK), .bus_current_high(BUS_CURRENT_HIGH), .bus_supply_pulse(BUS_SUPPLY_PULSE)
  );
  initial forever #25 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) begin
    if (SYNC_PULSE_EVENT === 1'h1) sync_cnt++;
    cyc++;
    if (cyc == 80000) begin
      num_errors++;
      stop_test();
    end
  end
  // ====================
  // Helpers
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  function automatic logic [15:0] frm(input logic [3:0] a, input logic [7:0] d,
                                      input logic [2:0] sv);
    return {^{a, d, sv}, a, d, sv};
  endfunction
  function automatic logic [15:0] cmd(input logic rw, input logic [3:0] a, input logic [7:0] d);
    return {2'h0, ^{rw, a, d}, rw, a, d};
  endfunction
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    {AWADDR, WDATA, AWVALID, WVALID, BREADY} <= {a, d, 3'h7};
    do begin
      @(posedge REF_CLK);
      if (AWREADY === 1'h1) AWVALID <= 1'h0;
      if (WREADY === 1'h1) WVALID <= 1'h0;
    end while (BVALID !== 1'h1);
    rr = BRESP;
    BREADY <= 1'h0;
  endtask
  task automatic axi_read(input logic [7:0] a);
    @(posedge REF_CLK);
    {ARADDR, ARVALID, RREADY} <= {a, 2'h3};
    do begin
      @(posedge REF_CLK);
      if (ARREADY === 1'h1) ARVALID <= 1'h0;
    end while (RVALID !== 1'h1);
    {rd, rr} = {RDATA, RRESP};
    RREADY <= 1'h0;
  endtask
  task automatic xfer(input logic [15:0] v, input int bits);
    cmsl_host_model_inst.send_frame(v, bits);
    cmsl_host_model_inst.recv_frame(pl, ok);
  endtask
  task automatic do_cmd(input logic rw, input logic [3:0] a, input logic [7:0] d,
                        input logic [15:0] exp);
    xfer(cmd(rw, a, d), 14);
    check(ok, 1'h1, "reply framing");
    check(pl, exp, "reply payload");
  endtask
  // ====================
  // Scenarios
  task automatic t_reset;
    @(posedge REF_CLK);
    SUPPLY_FAIL <= 1'h1;
    repeat (10) @(posedge REF_CLK);
    check(BUS_CURRENT_HIGH, 1'h0, "idle in fail");
    check(ANALOG_TEST_OUTPUT_ENABLE, 1'h0, "test out off");
    SUPPLY_FAIL <= 1'h0;
    axi_read(8'h04);
    check(rd[1:0], 2'h0, "phase one");
    $display("reset test done");
  endtask
  task automatic t_key;
    xfer(16'hA5A5, 16);
    check(ok, 1'h0, "wrong key ignored");
    xfer(16'h5A5A, 16);
    check(ok, 1'h1, "key reply framing");
    check(pl, frm(4'h2, 8'h00, 3'h5), "key reply");
    check(CONFIG_MODE, 1'h1, "config entered");
    $display("key test done");
  endtask
  task automatic t_rw;
    do_cmd(1'h0, 4'h2, 8'h01, frm(4'h2, 8'h01, 3'h5));
    check(ANALOG_TEST_OUTPUT_ENABLE, 1'h1, "test out on");
    xfer(cmd(1'h0, 4'h2, 8'h54) ^ 16'h2000, 14);
    check(pl, frm(4'h0, 8'h00, 3'h6), "parity reply");
    do_cmd(1'h1, 4'h2, 8'hFF, frm(4'h2, 8'h01, 3'h5));
    cmsl_host_model_inst.send_frame(16'h001F, 5);
    repeat (500) @(posedge REF_CLK);
    do_cmd(1'h1, 4'h2, 8'h00, frm(4'h2, 8'h01, 3'h5));
    axi_read(8'h48);
    check(rd, 32'h1, "register mirror");
    $display("read write test done");
  endtask
  task automatic t_lock;
    do_cmd(1'h0, 4'h2, 8'h81, frm(4'h2, 8'h81, 3'h5));
    do_cmd(1'h0, 4'h2, 8'h00, frm(4'h2, 8'h81, 3'h5));
    axi_write(8'hFC, 32'h1);
    check(rr, 2'h2, "unmapped write");
    axi_read(8'hFC);
    check(rr, 2'h2, "unmapped read");
    axi_write(8'h00, 32'h1);
    axi_read(8'h00);
    check({rr, rd[0]}, 3'h1, "sync mode set");
    $display("lock test done");
  endtask
  task automatic t_exit;
    do_cmd(1'h0, 4'hA, 8'h80, frm(4'hA, 8'h80, 3'h5));
    check(CONFIG_MODE, 1'h0, "config left");
    repeat (6100) @(posedge REF_CLK);
    n = sync_cnt;
    xfer(16'h5A5A, 16);
    check(ok, 1'h0, "late key ignored");
    check(sync_cnt - n, 32'd16, "sync events");
    axi_read(8'h04);
    check(rd[1:0], 2'h2, "normal mode");
    $display("exit test done");
  endtask
  initial begin
    repeat (3) @(posedge REF_CLK);
    RSTN <= 1'h1;
    t_reset();
    t_key();
    t_rw();
    t_lock();
    t_exit();
    stop_test();
  end
endmodule
